// ---- rtl/hrr_core.sv ----
// Purpose: Per-channel HART response record builder behind an APB slave
// Assumes: One clock; the host side fills in field results through registers
// Notes: Records are read word by word, four record bytes per word
// Notes on behaviour
// - Control byte at position 0, group error byte at position 1 always.
// - On failure, protocol error at 2; data follow only for result 6.
// - On success, data from position 2 only for result 4.
// - Bits 0..2 of control hold processing status codes 0 to 7.
// - Success reports 4 with data, 5 without.
// - Failure reports 6 with data, 7 without.
// - Control bit 3 is 0, burst mode never active.
// - Control bit 4 is 0, data come straight from field device.
// - Control bit 5 is 0, transparent message format.
// - Control bit 6 mirrors sequence mode; bit 7 is 0 for responses.
// - Group bit 0 set when more status is available.
// - Group bit 1 set when device saw a communication error.
// - Group bit 2 asks for modem unit parameter check; bit 3 is 0.
// - Group bits 4..7 carry category 0 to 8; 9 to 15 unused.
// - Modem unit codes 0..5 defined, higher reserved or vendor.
// - Channel fault codes 0..5 defined, higher reserved or vendor.
// - Query error flags on bits 1,3,4,5,6; bits 0 and 2 zero.
// - Response error flags on bits 0 to 6.
// - Rejected query codes 0..4 defined.
// - Profile and vendor rejections give protocol error 0.
// - Channels 0..3 use records 81,83,85,87 paired with 80,82,84,86.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module hrr_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [3:0] chan_busy
);
   typedef struct packed {
      logic [hrr_pkg::NUM_CH-1:0][2:0] result;
      logic [hrr_pkg::NUM_CH-1:0] seq_mode;
      logic [hrr_pkg::NUM_CH-1:0][7:0] group;
      logic [hrr_pkg::NUM_CH-1:0][7:0] perr;
      logic [hrr_pkg::NUM_CH-1:0][7:0] dlen;
      logic [hrr_pkg::NUM_CH-1:0][7:0] wlen;
      logic [7:0] st_group;
      logic [7:0] st_perr;
      logic [hrr_pkg::CH_BITS-1:0] st_ch;
      logic [31:0] rdata;
      logic err;
   } hrr_state_t;

   hrr_state_t st;
   hrr_state_t next_st;
   // Staged field answer bytes, one bank per channel
   logic [7:0] stage_mem [hrr_pkg::NUM_CH][hrr_pkg::DATA_MAX];
   // Bytes visible in the record; copied from the stage at completion only
   logic [7:0] rec_mem [hrr_pkg::NUM_CH][hrr_pkg::DATA_MAX];

   logic acc;
   logic wr;
   logic rd;
   logic [hrr_pkg::CH_BITS-1:0] wch;
   logic [7:0] widx;
   logic stage_wr;
   logic commit;
   logic [hrr_pkg::CH_BITS-1:0] rch;
   logic [7:0] rbyte;
   logic in_rec;
   logic setup;
   logic wr_map;

   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign pready = 1'b1;
   assign pslverr = st.err;
   assign prdata = st.rdata;
   assign in_rec = (paddr >= hrr_pkg::ADDR_RECORD) && (paddr < hrr_pkg::ADDR_REC_END);
   assign rch = paddr[hrr_pkg::REC_STRIDE_LOG2 +: hrr_pkg::CH_BITS];
   assign rbyte = {paddr[7:2], 2'h0};
   assign wch = pwdata[9:8];
   assign widx = pwdata[23:16];
   assign stage_wr = wr && (paddr == hrr_pkg::ADDR_DATA) && (widx < 8'(hrr_pkg::DATA_MAX));
   assign commit = wr && (paddr == hrr_pkg::ADDR_COMPLETE);
   // Answers are prepared in the setup cycle so they stand at the access edge
   assign setup = psel && !penable;
   assign wr_map = (paddr == hrr_pkg::ADDR_CTRL) || (paddr == hrr_pkg::ADDR_FIELD) ||
                   (paddr == hrr_pkg::ADDR_ERROR) || (paddr == hrr_pkg::ADDR_DATA) ||
                   (paddr == hrr_pkg::ADDR_COMPLETE);

   always_comb begin
      for (int c = 0; c < hrr_pkg::NUM_CH; c++) begin
         chan_busy[c] = (st.result[c] == hrr_pkg::HRR_WAITING) ||
                        (st.result[c] == hrr_pkg::HRR_EXECUTING);
      end
   end

   // Masks command, query and response errors to their defined bits; modem, channel and rejected codes pass unchanged, other categories give 0
   function automatic logic [7:0] clean_perr(input logic [3:0] cat, input logic [7:0] v);
      logic [7:0] r;
      r = 8'h00;
      unique case (cat)
         hrr_pkg::CAT_MODEM:
            r = v;
         hrr_pkg::CAT_CHANNEL:
            r = v;
         hrr_pkg::CAT_COMMAND:
            r = v & hrr_pkg::CMD_MASK;
         hrr_pkg::CAT_QUERY:
            r = v & hrr_pkg::QUERY_MASK;
         hrr_pkg::CAT_RESPONSE:
            r = v & hrr_pkg::RESP_MASK;
         hrr_pkg::CAT_REJECTED:
            r = v;
         default:
            r = 8'h00;
      endcase
      return r;
   endfunction

   // Record byte i of channel c as the host sees it
   function automatic logic [7:0] rec_byte(input int c, input logic [7:0] i);
      logic [7:0] b;
      logic [2:0] res;
      logic err;
      logic with_data;
      logic [7:0] base;
      b = 8'h00;
      res = st.result[c];
      err = (res == hrr_pkg::HRR_ERR_DATA) || (res == hrr_pkg::HRR_ERR_NODATA);
      with_data = (res == hrr_pkg::HRR_OK_DATA) || (res == hrr_pkg::HRR_ERR_DATA);
      base = err ? 8'(hrr_pkg::POS_DATA_ERR) : 8'(hrr_pkg::POS_DATA_OK);
      if (i == 8'(hrr_pkg::POS_CTRL)) begin
         b[2:0] = res;
         b[hrr_pkg::CB_BURST] = 1'b0;
         b[hrr_pkg::CB_SOURCE] = 1'b0;
         b[hrr_pkg::CB_FORMAT] = 1'b0;
         b[hrr_pkg::CB_SEQ] = st.seq_mode[c];
         b[hrr_pkg::CB_DIR] = 1'b0;
      end else if (i == 8'(hrr_pkg::POS_GROUP)) begin
         b = st.group[c];
      end else if (err && i == 8'(hrr_pkg::POS_PERR)) begin
         b = st.perr[c];
      end else if (with_data && i >= base && (i - base) < st.dlen[c]) begin
         b = rec_mem[c][i - base];
      end
      return b;
   endfunction

   always_comb begin
      logic [3:0] cat;
      logic ok;
      logic have;
      logic [7:0] g;
      cat = pwdata[15:12];
      ok = pwdata[0];
      have = pwdata[1];
      g = 8'h00;
      next_st = st;
      next_st.err = 1'b0;
      if (wr) begin
         unique case (paddr)
            hrr_pkg::ADDR_CTRL: begin
               // Request accepted: result goes to waiting, or to executing when bit 2 is set, until completion
               if (pstrb[0]) begin
                  next_st.result[wch] = pwdata[2] ? hrr_pkg::HRR_EXECUTING
                                                   : hrr_pkg::HRR_WAITING;
                  next_st.seq_mode[wch] = pwdata[hrr_pkg::CB_SEQ];
                  next_st.wlen[wch] = 8'h00;
               end
            end
            hrr_pkg::ADDR_FIELD: begin
               g[hrr_pkg::GE_MORE_STATUS] = pwdata[0];
               g[hrr_pkg::GE_COMM_ERR] = pwdata[1];
               g[hrr_pkg::GE_PARAM_CHECK] = pwdata[2];
               g[hrr_pkg::GE_RSV] = 1'b0;
               g[7:hrr_pkg::GE_CAT_LSB] = (cat > hrr_pkg::CAT_LAST) ? hrr_pkg::CAT_UNSPEC : cat;
               next_st.st_group = g;
               next_st.st_ch = wch;
               // A new job must not inherit the last job's protocol error byte
               next_st.st_perr = 8'h00;
            end
            hrr_pkg::ADDR_ERROR: begin
               next_st.st_perr = clean_perr(st.st_group[7:hrr_pkg::GE_CAT_LSB], pwdata[7:0]);
            end
            hrr_pkg::ADDR_DATA: begin
               if (stage_wr && (widx + 8'h01) > st.wlen[wch]) begin
                  next_st.wlen[wch] = widx + 8'h01;
               end
            end
            hrr_pkg::ADDR_COMPLETE: begin
               // All record bytes switch in this one edge
               next_st.group[wch] = st.st_group;
               next_st.perr[wch] = ok ? 8'h00 : st.st_perr;
               next_st.dlen[wch] = have ? st.wlen[wch] : 8'h00;
               if (ok) begin
                  next_st.result[wch] = have ? hrr_pkg::HRR_OK_DATA
                                             : hrr_pkg::HRR_OK_NODATA;
               end else begin
                  next_st.result[wch] = have ? hrr_pkg::HRR_ERR_DATA
                                             : hrr_pkg::HRR_ERR_NODATA;
               end
            end
            default: begin
               // Unmapped writes are flagged in their setup cycle
            end
         endcase
      end
      // Slave error stands through the access cycle only
      if (setup && pwrite) begin
         next_st.err = !wr_map;
      end
      // Read data are fetched at the setup edge and hold until the next read
      if (setup && !pwrite) begin
         next_st.rdata = 32'h0000_0000;
         if (in_rec) begin
            for (int k = 0; k < 4; k++) begin
               next_st.rdata[8*k +: 8] = rec_byte(int'(rch), rbyte + 8'(k));
            end
         end else if (paddr == hrr_pkg::ADDR_STATUS) begin
            for (int c = 0; c < hrr_pkg::NUM_CH; c++) begin
               next_st.rdata[8*c +: 8] = rec_byte(c, 8'(hrr_pkg::POS_CTRL));
            end
         end else if (paddr == hrr_pkg::ADDR_CTRL) begin
            next_st.rdata[7:0] = hrr_pkg::REC_REQ_BASE;
            next_st.rdata[15:8] = hrr_pkg::REC_RESP_BASE;
         end else begin
            next_st.err = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk) begin
      if (stage_wr) begin
         stage_mem[wch][widx] <= pwdata[31:24];
      end
      if (commit) begin
         for (int i = 0; i < hrr_pkg::DATA_MAX; i++) begin
            rec_mem[wch][i] <= stage_mem[wch][i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   a_rsv_bits: assert property (@(posedge pclk) disable iff (!presetn)
      st.group[0][hrr_pkg::GE_RSV] == 1'b0) else $error("group reserved bit set");
   a_cat_range: assert property (@(posedge pclk) disable iff (!presetn)
      st.group[0][7:4] <= hrr_pkg::CAT_LAST) else $error("category out of range");
   a_commit_ok: assert property (@(posedge pclk) disable iff (!presetn)
      commit && pwdata[0] && pwdata[1] |=> st.result[$past(wch)] == hrr_pkg::HRR_OK_DATA)
      else $error("success with data not 4");
   a_commit_err: assert property (@(posedge pclk) disable iff (!presetn)
      commit && !pwdata[0] && !pwdata[1] |=> st.result[$past(wch)] == hrr_pkg::HRR_ERR_NODATA)
      else $error("error without data not 7");
   a_wait_hold: assert property (@(posedge pclk) disable iff (!presetn)
      chan_busy[0] && !(wr && wch == 2'h0) |=> chan_busy[0]) else $error("wait left early");
   a_ok_perr: assert property (@(posedge pclk) disable iff (!presetn)
      st.result[0] == hrr_pkg::HRR_OK_NODATA |-> st.perr[0] == 8'h00)
      else $error("success with protocol error");
   a_query_bits: assert property (@(posedge pclk) disable iff (!presetn)
      st.st_group[7:4] == hrr_pkg::CAT_QUERY |-> (st.st_perr & 8'h85) == 8'h00)
      else $error("query reserved bit set");
   a_rej_zero: assert property (@(posedge pclk) disable iff (!presetn)
      st.st_group[7:4] >= hrr_pkg::CAT_PROFILE |-> st.st_perr == 8'h00)
      else $error("profile rejection not zero");
   a_read_ok: assert property (@(posedge pclk) disable iff (!presetn)
      rd && in_rec && paddr[7:0] == 8'h00 |=> prdata[7] == 1'b0)
      else $error("control byte direction bit set");
   a_st_rsv: assert property (@(posedge pclk) disable iff (!presetn)
      st.st_group[hrr_pkg::GE_RSV] == 1'b0) else $error("staged reserved bit set");
   a_st_cat: assert property (@(posedge pclk) disable iff (!presetn)
      st.st_group[7:4] <= hrr_pkg::CAT_LAST) else $error("staged category out of range");
   a_commit_okn: assert property (@(posedge pclk) disable iff (!presetn)
      commit && pwdata[0] && !pwdata[1] |=> st.result[$past(wch)] == hrr_pkg::HRR_OK_NODATA)
      else $error("success without data not 5");
   a_commit_errd: assert property (@(posedge pclk) disable iff (!presetn)
      commit && !pwdata[0] && pwdata[1] |=> st.result[$past(wch)] == hrr_pkg::HRR_ERR_DATA)
      else $error("error with data not 6");
   a_start_wait: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == hrr_pkg::ADDR_CTRL && pstrb[0] |=> chan_busy[$past(wch)])
      else $error("accepted request not waiting");
   a_resp_top: assert property (@(posedge pclk) disable iff (!presetn)
      st.st_group[7:4] == hrr_pkg::CAT_RESPONSE |-> st.st_perr[7] == 1'b0)
      else $error("response error reserved bit set");
   a_status_fix: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == hrr_pkg::ADDR_STATUS
      |=> (prdata & 32'hB8B8_B8B8) == 32'h0000_0000)
      else $error("fixed control bits set");
   a_status_res: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == hrr_pkg::ADDR_STATUS
      |=> prdata[2:0] == $past(st.result[0]))
      else $error("status result wrong");
   a_status_seq: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == hrr_pkg::ADDR_STATUS
      |=> prdata[hrr_pkg::CB_SEQ] == $past(st.seq_mode[0]))
      else $error("sequence mode bit wrong");
   a_rec_map: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == hrr_pkg::ADDR_CTRL
      |=> prdata[15:0] == {hrr_pkg::REC_RESP_BASE, hrr_pkg::REC_REQ_BASE})
      else $error("record numbers wrong");
   a_data_gate: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && in_rec && paddr[7:0] == 8'h04 &&
      st.result[rch] == hrr_pkg::HRR_ERR_NODATA |=> prdata == 32'h0000_0000)
      else $error("data shown without data");
   a_nodata_ok: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && in_rec && paddr[7:0] == 8'h00 &&
      st.result[rch] == hrr_pkg::HRR_OK_NODATA |=> prdata[31:16] == 16'h0000)
      else $error("success shows data without data");
   a_err_access: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> psel && penable) else $error("slave error outside access");
   // Same record invariants for every channel
   for (genvar c = 0; c < hrr_pkg::NUM_CH; c++) begin : g_ch_chk
      a_ch_rsv: assert property (@(posedge pclk) disable iff (!presetn)
         st.group[c][hrr_pkg::GE_RSV] == 1'b0) else $error("channel reserved bit set");
      a_ch_cat: assert property (@(posedge pclk) disable iff (!presetn)
         st.group[c][7:4] <= hrr_pkg::CAT_LAST) else $error("channel category too big");
      a_ch_okp: assert property (@(posedge pclk) disable iff (!presetn)
         st.result[c] == hrr_pkg::HRR_OK_DATA |-> st.perr[c] == 8'h00)
         else $error("channel success with protocol error");
   end
   c_ok_data: cover property (@(posedge pclk) disable iff (!presetn)
      st.result[0] == hrr_pkg::HRR_OK_DATA);
   c_err_data: cover property (@(posedge pclk) disable iff (!presetn)
      st.result[1] == hrr_pkg::HRR_ERR_DATA);
   c_seq: cover property (@(posedge pclk) disable iff (!presetn) st.seq_mode[2]);
   c_rec_read: cover property (@(posedge pclk) disable iff (!presetn) rd && in_rec);
   c_err_nodata: cover property (@(posedge pclk) disable iff (!presetn)
      st.result[1] == hrr_pkg::HRR_ERR_NODATA);
endmodule // hrr_core
`default_nettype wire

// ---- rtl/hrr_pkg.sv ----
// Purpose: Constants for the HART response record builder
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Record byte positions, codes and register map
package hrr_pkg;
   localparam int NUM_CH = 4;
   localparam int REC_BYTES = 240;
   localparam int DATA_MAX = 238;
   // Record byte positions
   localparam int POS_CTRL = 0;
   localparam int POS_GROUP = 1;
   localparam int POS_PERR = 2;
   localparam int POS_DATA_OK = 2;
   localparam int POS_DATA_ERR = 3;
   // Record numbers per channel
   localparam logic [7:0] REC_RESP_BASE = 8'h51;
   localparam logic [7:0] REC_REQ_BASE = 8'h50;
   // Result codes, bits 0 to 2 of the control byte
   typedef enum logic [2:0] {
      HRR_INACTIVE = 3'h0, HRR_INACTIVE_RSV = 3'h1, HRR_WAITING = 3'h2,
      HRR_EXECUTING = 3'h3, HRR_OK_DATA = 3'h4, HRR_OK_NODATA = 3'h5,
      HRR_ERR_DATA = 3'h6, HRR_ERR_NODATA = 3'h7
   } hrr_result_t;
   // Control byte bit positions
   localparam int CB_BURST = 3;
   localparam int CB_SOURCE = 4;
   localparam int CB_FORMAT = 5;
   localparam int CB_SEQ = 6;
   localparam int CB_DIR = 7;
   // Group error byte bit positions
   localparam int GE_MORE_STATUS = 0;
   localparam int GE_COMM_ERR = 1;
   localparam int GE_PARAM_CHECK = 2;
   localparam int GE_RSV = 3;
   localparam int GE_CAT_LSB = 4;
   // Protocol error categories
   localparam logic [3:0] CAT_UNSPEC = 4'h0;
   localparam logic [3:0] CAT_MODEM = 4'h1;
   localparam logic [3:0] CAT_CHANNEL = 4'h2;
   localparam logic [3:0] CAT_COMMAND = 4'h3;
   localparam logic [3:0] CAT_QUERY = 4'h4;
   localparam logic [3:0] CAT_RESPONSE = 4'h5;
   localparam logic [3:0] CAT_REJECTED = 4'h6;
   localparam logic [3:0] CAT_PROFILE = 4'h7;
   localparam logic [3:0] CAT_VENDOR = 4'h8;
   localparam logic [3:0] CAT_LAST = 4'h8;
   // Largest defined codes, vendor code start and defined-bit masks per category
   localparam logic [7:0] MODEM_MAX = 8'h05;
   localparam logic [7:0] CHAN_MAX = 8'h05;
   localparam logic [7:0] REJ_MAX = 8'h04;
   localparam logic [7:0] VENDOR_LO = 8'h80;
   localparam logic [7:0] QUERY_MASK = 8'h7A;
   localparam logic [7:0] RESP_MASK = 8'h7F;
   localparam logic [7:0] CMD_MASK = 8'h7F;
   // Register map, byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_FIELD = 12'h008;
   localparam logic [11:0] ADDR_ERROR = 12'h00C;
   localparam logic [11:0] ADDR_DATA = 12'h010;
   localparam logic [11:0] ADDR_COMPLETE = 12'h014;
   localparam logic [11:0] ADDR_RECORD = 12'h800;
   localparam logic [11:0] ADDR_REC_END = 12'hC00;
   localparam int REC_STRIDE_LOG2 = 8;
   localparam int CH_BITS = 2;
   localparam int IDX_BITS = 8;
endpackage

// ---- dv/hrr_host.sv ----
// Purpose: APB host model that issues register transfers to the record builder
// Assumes: Read data and slave error stand at the edge that samples pready high
// Notes: The bench calls xfer hierarchically; one idle cycle between transfers
`timescale 1ns/1ps
`default_nettype none
module hrr_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
   end

   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines must not look like a held request
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // hrr_host
`default_nettype wire

// ---- dv/hart_response_record_status_test.sv ----
// Purpose: Self-checking bench for the response record builder
// Assumes: Record bytes read four to a word, data staged before completion
// Notes: Data bytes A5 then 5A are staged for every job
`timescale 1ns/1ps
`default_nettype none
module hart_response_record_status_test;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] chan_busy;
   int n_fail;
   int check_count;
   localparam logic [3:0] CAT_IN [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                                          4'h8, 4'h9};
   localparam logic [7:0] ERR_IN [10] = '{8'h11, 8'h05, 8'h03, 8'hFF, 8'h85, 8'hFF, 8'h04,
                                          8'h33, 8'h44, 8'h11};
   localparam logic [7:0] ERR_EXP [10] = '{8'h00, 8'h05, 8'h03, 8'h7F, 8'h00, 8'h7F, 8'h04,
                                           8'h00, 8'h00, 8'h00};

   hrr_core i_hrr_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .chan_busy(chan_busy));
   hrr_host i_hrr_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   always #20 pclk = ~pclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      i_hrr_host.xfer(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      logic e;
      i_hrr_host.xfer(1'b0, a, 32'h0000_0000, v, e);
   endtask

   function automatic logic [11:0] rec(input logic [1:0] ch, input int n);
      return hrr_pkg::ADDR_RECORD + {2'b00, ch, 8'h00} + 12'(4 * n);
   endfunction

   // One full job: start, stage, confirm executing, complete, judge the record
   task automatic run_job(input logic [1:0] ch, input logic [31:0] fld, input logic [7:0] err,
                          input logic [1:0] done, input logic [31:0] exp);
      logic [31:0] v;
      wr(hrr_pkg::ADDR_CTRL, {22'h0, ch, 8'h04});
      rd(rec(ch, 0), v);
      check({24'h0, v[7:0]}, 32'h0000_0003);
      check({31'h0, chan_busy[ch]}, 32'h0000_0001);
      wr(hrr_pkg::ADDR_FIELD, fld | {22'h0, ch, 8'h00});
      wr(hrr_pkg::ADDR_ERROR, {24'h0, err});
      wr(hrr_pkg::ADDR_DATA, {8'hA5, 8'h00, 6'h0, ch, 8'h00});
      wr(hrr_pkg::ADDR_DATA, {8'h5A, 8'h01, 6'h0, ch, 8'h00});
      rd(rec(ch, 0), v);
      check({24'h0, v[7:0]}, 32'h0000_0003);
      wr(hrr_pkg::ADDR_COMPLETE, {22'h0, ch, 6'h0, done});
      rd(rec(ch, 0), v);
      check(v, exp);
      rd(rec(ch, 1), v);
      // On failure with data the second staged byte lands at position 4
      check(v, (done == 2'b10) ? 32'h0000_005A : 32'h0000_0000);
      check({31'h0, chan_busy[ch]}, 32'h0000_0000);
   endtask

   task automatic t_reset;
      logic [31:0] v;
      rd(hrr_pkg::ADDR_CTRL, v);
      check({16'h0, v[15:0]}, 32'h0000_5150);
      rd(hrr_pkg::ADDR_STATUS, v);
      check(v, 32'h0000_0000);
      rd(rec(2'd3, 0), v);
      check(v, 32'h0000_0000);
      check({28'h0, chan_busy}, 32'h0000_0000);
   endtask

   task automatic t_wait_modes;
      logic [31:0] v;
      wr(hrr_pkg::ADDR_CTRL, {22'h0, 2'd2, 8'h40});
      wr(hrr_pkg::ADDR_CTRL, {22'h0, 2'd3, 8'h44});
      rd(hrr_pkg::ADDR_STATUS, v);
      check(v, 32'h4342_0000);
      check({28'h0, chan_busy}, 32'h0000_000C);
   endtask

   task automatic t_success;
      logic [31:0] v;
      // Bit 3 of the staged flags must not reach the group byte
      run_job(2'd0, 32'h0000_000D, 8'h00, 2'b11, 32'h5AA5_0504);
      run_job(2'd1, 32'h0000_0002, 8'h00, 2'b01, 32'h0000_0205);
      rd(hrr_pkg::ADDR_STATUS, v);
      check({16'h0, v[15:0]}, 32'h0000_0504);
   endtask

   task automatic t_fail;
      run_job(2'd0, {16'h0, hrr_pkg::CAT_QUERY, 12'h002}, 8'hFF, 2'b10,
              32'hA57A_4206);
   endtask

   task automatic t_categories;
      logic [3:0] cat;
      for (int i = 0; i < 10; i++) begin
         cat = (CAT_IN[i] > 4'h8) ? 4'h0 : CAT_IN[i];
         run_job(2'd1, {16'h0, CAT_IN[i], 12'h000}, ERR_IN[i], 2'b00,
                 {8'h00, ERR_EXP[i], cat, 4'h0, 8'h07});
      end
   endtask

   task automatic t_unmapped;
      logic [31:0] v;
      logic e;
      i_hrr_host.xfer(1'b0, 12'h7F0, 32'h0000_0000, v, e);
      check({31'h0, e}, 32'h0000_0001);
      i_hrr_host.xfer(1'b1, 12'h7F0, 32'h0000_0000, v, e);
      check({31'h0, e}, 32'h0000_0001);
      i_hrr_host.xfer(1'b0, hrr_pkg::ADDR_CTRL, 32'h0000_0000, v, e);
      check({31'h0, e}, 32'h0000_0000);
   endtask

   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      n_fail = 0;
      check_count = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_wait_modes();
      t_success();
      t_fail();
      t_categories();
      t_unmapped();
      give_verdict();
   end

   // About 500 cycles are needed; a hang past 20000 cycles ends the run
   initial begin
      #(40 * 20000);
      n_fail++;
      give_verdict();
   end
endmodule // hart_response_record_status_test
`default_nettype wire
